//--- logic/dsp_clock_memory_pkg.sv
package dsp_clock_memory_pkg;
    // Register indices on the control interface
    localparam logic [15:0] ADDR_CORE2_MEMORY_STATUS   = 16'h1204;
    localparam logic [15:0] ADDR_CORE2_CLOCK_STATUS    = 16'h1206;
    localparam logic [15:0] ADDR_CORE3_CONTROL         = 16'h1300;
    localparam logic [15:0] ADDR_CORE3_CLOCK_CONFIG    = 16'h1301;
    localparam logic [15:0] ADDR_CORE3_MEMORY_STATUS   = 16'h1304;
    localparam logic [15:0] ADDR_CORE3_CLOCK_STATUS    = 16'h1306;
    localparam logic [15:0] ADDR_CORE3_COLLISION       = 16'h1307;
    // Field positions
    localparam int          BIT_RUN_ENABLE             = 0;
    localparam int          BIT_CLOCK_GATE             = 2;
    localparam int          BIT_MEMORY_RETAIN          = 4;
    localparam int          BIT_MEMORY_READY           = 0;
    localparam int          BIT_CLOCK_PRESENT          = 0;
    localparam int          LSB_FREQ_READBACK          = 1;
    // Reset values, then the reserved clock select code
    localparam logic        RST_MEMORY_RETAIN          = 1'h1;
    localparam logic        RST_CLOCK_GATE             = 1'h0;
    localparam logic        RST_RUN_ENABLE             = 1'h0;
    localparam logic [2:0]  RST_FREQ_SELECT            = 3'h0;
    localparam logic [15:0] RST_CLASH_ADDRESS          = 16'h0000;
    localparam logic [2:0]  FREQ_RESERVED              = 3'h7;
    // System clock in kHz, then the 44.1kHz family decode of the sample rate code
    localparam int          SYSTEM_CLOCK_KHZ           = 250000;
    localparam logic [4:0]  RATE_FAMILY_MASK           = 5'h18;
    localparam logic [4:0]  RATE_FAMILY_44K1           = 5'h08;
    // Memory clearing walks one word per cycle
    localparam int          CLEAR_WORDS                = 1024;
endpackage : dsp_clock_memory_pkg

//--- logic/dsp_clock_memory_control.sv
// Contract
// - Each core has a read-only memory-ready bit, 0 until its memory is usable, and hosts wait for it.
// - The 3-bit clock select maps 000..110 to 6.144..147.456 MHz and 111 is reserved.
// - With a 44.1kHz-family sample rate code (01XXX) each select code gives the lower family rate.
// - Bits 3:1 of the clock status report the running clock code, valid only while it is enabled.
// - Bit 0 of the clock status reads 1 while the core clock is present, for legacy use only.
// - With memory retain at 0 the core memory is cleared while the clock gate is 0 and in soft resets.
// - With memory retain at 1, its default, memory is kept while gated off and through resets.
// - The clock gate bit, default 0, gates the core clock and must be set before core access.
// - A shared-memory collision loads the 16-bit clash address field, which resets to 0000h.
// - The clash address is a word offset from the shared data memory base, one 24-bit word per LSB.
`timescale 1ns/10ps
`default_nettype none
module dsp_clock_memory_control #(
    parameter int unsigned ADDR_W      = 16,
    parameter int unsigned CLEAR_WORDS = dsp_clock_memory_pkg::CLEAR_WORDS
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              arst_n,
    input  wire logic              soft_reset,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    input  wire logic [15:0]       reg_wdata,
    output logic      [15:0]       reg_rdata,
    // Sample rate in use
    input  wire logic [4:0]        sample_rate_code,
    // Second core status inputs
    input  wire logic              core2_memory_ready_in,
    input  wire logic              core2_clock_on,
    input  wire logic [2:0]        core2_freq_code,
    // Third core shared memory
    input  wire logic              core3_clash,
    input  wire logic [15:0]       core3_clash_word,
    // Third core outputs
    output logic                   core3_clock_enable,
    output logic                   core3_run_enable,
    output logic [2:0]             core3_divide_code,
    output logic                   core3_family_44k1,
    output logic                   core3_memory_clear,
    output logic [15:0]            core3_clear_address
);
    logic        rst_meta;
    logic        rst_n;
    logic        sr_meta;
    logic        sr_sync;
    logic        mr2_meta;
    logic        mr2_sync;
    logic        co2_meta;
    logic        co2_sync;
    logic [2:0]  fc2_meta;
    logic [2:0]  fc2_sync;
    logic [4:0]  rate_meta;
    logic [4:0]  rate_sync;
    logic        clash_meta;
    logic        clash_sync;
    logic        clash_prev;
    logic [15:0] word_meta;
    logic [15:0] word_sync;

    logic        core3_memory_retain;
    logic        core3_clock_gate;
    logic [2:0]  core3_clock_freq_select;
    logic [15:0] core3_shared_mem_clash_address;
    logic        clearing;
    logic [15:0] clear_count;
    logic        clear_done;
    logic        core3_memory_ready;
    logic        next_memory_retain;
    logic        next_clock_gate;
    logic        next_run_enable;
    logic [2:0]  next_freq_select;
    logic [15:0] next_clash_address;
    logic        next_clearing;
    logic [15:0] next_clear_count;
    logic        next_clear_done;
    logic        next_memory_ready;
    logic [15:0] next_rdata;
    logic        clear_request;

    // Reset release and pin synchronisers
    always_ff @(posedge clk_sys or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta <= 1'b0;
            rst_n    <= 1'b0;
        end
        else
        begin
            rst_meta <= 1'b1;
            rst_n    <= rst_meta;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            {sr_meta, sr_sync, mr2_meta, mr2_sync, co2_meta, co2_sync} <= 6'h00;
            fc2_meta   <= 3'h0;
            fc2_sync   <= 3'h0;
            rate_meta  <= 5'h00;
            rate_sync  <= 5'h00;
            clash_meta <= 1'b0;
            clash_sync <= 1'b0;
            clash_prev <= 1'b0;
            word_meta  <= 16'h0000;
            word_sync  <= 16'h0000;
        end
        else
        begin
            sr_meta    <= soft_reset;
            sr_sync    <= sr_meta;
            mr2_meta   <= core2_memory_ready_in;
            mr2_sync   <= mr2_meta;
            co2_meta   <= core2_clock_on;
            co2_sync   <= co2_meta;
            fc2_meta   <= core2_freq_code;
            fc2_sync   <= fc2_meta;
            rate_meta  <= sample_rate_code;
            rate_sync  <= rate_meta;
            clash_meta <= core3_clash;
            clash_sync <= clash_meta;
            clash_prev <= clash_sync;
            word_meta  <= core3_clash_word;
            word_sync  <= word_meta;
        end
    end

    // Clear runs when retain is off and either the gate is off or a soft reset hits
    assign clear_request = !core3_memory_retain && (!core3_clock_gate || sr_sync);

    always_comb
    begin
        next_memory_retain = core3_memory_retain;
        next_clock_gate    = core3_clock_gate;
        next_run_enable    = core3_run_enable;
        next_freq_select   = core3_clock_freq_select;
        next_clash_address = core3_shared_mem_clash_address;
        next_clearing      = clearing;
        next_clear_count   = clear_count;
        next_clear_done    = clear_done;
        next_memory_ready  = core3_memory_ready;
        next_rdata         = reg_rdata;
        if (sr_sync)
        begin
            // Software reset returns control fields; retain setting decides memory fate
            next_clock_gate    = dsp_clock_memory_pkg::RST_CLOCK_GATE;
            next_run_enable    = dsp_clock_memory_pkg::RST_RUN_ENABLE;
            next_freq_select   = dsp_clock_memory_pkg::RST_FREQ_SELECT;
            next_clash_address = dsp_clock_memory_pkg::RST_CLASH_ADDRESS;
        end
        else
        begin
            if (reg_write && reg_addr == ADDR_W'(dsp_clock_memory_pkg::ADDR_CORE3_CONTROL))
            begin
                next_memory_retain = reg_wdata[dsp_clock_memory_pkg::BIT_MEMORY_RETAIN];
                next_clock_gate    = reg_wdata[dsp_clock_memory_pkg::BIT_CLOCK_GATE];
                next_run_enable    = reg_wdata[dsp_clock_memory_pkg::BIT_RUN_ENABLE];
            end
            if (reg_write && reg_addr == ADDR_W'(dsp_clock_memory_pkg::ADDR_CORE3_CLOCK_CONFIG))
                next_freq_select = reg_wdata[2:0];
            if (clash_sync && !clash_prev)
                next_clash_address = word_sync;
        end
        // Memory clear sequencer: one wipe per gate-off, another on each soft reset
        // Restarting only when idle keeps the word walk unbroken while the request holds
        if (!clear_request)
            next_clear_done = 1'b0;
        if (clear_request && !clearing && (!clear_done || sr_sync))
        begin
            next_clearing     = 1'b1;
            next_clear_count  = 16'h0000;
            next_memory_ready = 1'b0;
        end
        else if (clearing)
        begin
            if (clear_count == 16'(CLEAR_WORDS - 1))
            begin
                next_clearing     = 1'b0;
                next_clear_done   = 1'b1;
                next_memory_ready = core3_clock_gate;
            end
            else
                next_clear_count = clear_count + 16'h0001;
        end
        else
            next_memory_ready = core3_clock_gate;
        next_rdata = 16'h0000;
        if (reg_read)
        begin
            case (reg_addr)
                ADDR_W'(dsp_clock_memory_pkg::ADDR_CORE2_MEMORY_STATUS):
                    next_rdata[dsp_clock_memory_pkg::BIT_MEMORY_READY] = mr2_sync;
                ADDR_W'(dsp_clock_memory_pkg::ADDR_CORE2_CLOCK_STATUS):
                    next_rdata[3:0] = {fc2_sync, co2_sync};
                ADDR_W'(dsp_clock_memory_pkg::ADDR_CORE3_CONTROL):
                    next_rdata[4:0] = {core3_memory_retain, 1'b0, core3_clock_gate, 1'b0,
                                       core3_run_enable};
                ADDR_W'(dsp_clock_memory_pkg::ADDR_CORE3_CLOCK_CONFIG):
                    next_rdata[2:0] = core3_clock_freq_select;
                ADDR_W'(dsp_clock_memory_pkg::ADDR_CORE3_MEMORY_STATUS):
                    next_rdata[dsp_clock_memory_pkg::BIT_MEMORY_READY] = core3_memory_ready;
                ADDR_W'(dsp_clock_memory_pkg::ADDR_CORE3_CLOCK_STATUS):
                    // Readback shows the code actually driving the divider
                    next_rdata[3:0] = {core3_divide_code, core3_clock_enable};
                ADDR_W'(dsp_clock_memory_pkg::ADDR_CORE3_COLLISION):
                    next_rdata = core3_shared_mem_clash_address;
                default:
                    next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            core3_memory_retain            <= dsp_clock_memory_pkg::RST_MEMORY_RETAIN;
            core3_clock_gate               <= dsp_clock_memory_pkg::RST_CLOCK_GATE;
            core3_run_enable               <= dsp_clock_memory_pkg::RST_RUN_ENABLE;
            core3_clock_freq_select        <= dsp_clock_memory_pkg::RST_FREQ_SELECT;
            core3_shared_mem_clash_address <= dsp_clock_memory_pkg::RST_CLASH_ADDRESS;
            clearing                       <= 1'b0;
            clear_count                    <= 16'h0000;
            clear_done                     <= 1'b0;
            core3_memory_ready             <= 1'b0;
            reg_rdata                      <= 16'h0000;
        end
        else
        begin
            core3_memory_retain            <= next_memory_retain;
            core3_clock_gate               <= next_clock_gate;
            core3_run_enable               <= next_run_enable;
            core3_clock_freq_select        <= next_freq_select;
            core3_shared_mem_clash_address <= next_clash_address;
            clearing                       <= next_clearing;
            clear_count                    <= next_clear_count;
            clear_done                     <= next_clear_done;
            core3_memory_ready             <= next_memory_ready;
            reg_rdata                      <= next_rdata;
        end
    end

    // Clock drive to the core: gated, reserved code holds the slowest rate
    always_ff @(posedge clk_sys or negedge rst_n)
    begin
        if (!rst_n)
        begin
            core3_clock_enable  <= 1'b0;
            core3_divide_code   <= 3'h0;
            core3_family_44k1   <= 1'b0;
            core3_memory_clear  <= 1'b0;
            core3_clear_address <= 16'h0000;
        end
        else
        begin
            core3_clock_enable  <= core3_clock_gate;
            core3_divide_code   <= (core3_clock_freq_select == dsp_clock_memory_pkg::FREQ_RESERVED)
                                   ? dsp_clock_memory_pkg::RST_FREQ_SELECT
                                   : core3_clock_freq_select;
            core3_family_44k1   <= (rate_sync & dsp_clock_memory_pkg::RATE_FAMILY_MASK)
                                   == dsp_clock_memory_pkg::RATE_FAMILY_44K1;
            core3_memory_clear  <= clearing;
            core3_clear_address <= clear_count;
        end
    end
endmodule : dsp_clock_memory_control
`default_nettype wire

//--- testbench/dsp_clock_memory_checker.sv
`timescale 1ns/10ps
`default_nettype none
module dsp_clock_memory_checker #(
    parameter int unsigned ADDR_W      = 16,
    parameter int unsigned CLEAR_WORDS = 8
) (
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              arst_n,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    input  wire logic [15:0]       reg_wdata,
    input  wire logic [15:0]       reg_rdata,
    // Third core
    input  wire logic [4:0]        sample_rate_code,
    input  wire logic              core3_clock_enable,
    input  wire logic [2:0]        core3_divide_code,
    input  wire logic              core3_family_44k1,
    input  wire logic              core3_memory_clear,
    input  wire logic [15:0]       core3_clear_address
);
    logic [15:0] a;
    logic        fam;
    assign a = 16'(reg_addr);
    assign fam = sample_rate_code[4:3] == 2'b01;
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    a_reserved_code: assert property (core3_divide_code != 3'h7)
        else $error("reserved code on divide output");
    // Select register lands one edge after the write, the divide output one edge later
    a_select_divide: assert property (reg_write && a == 16'h1301 |-> ##2
        core3_divide_code == (($past(reg_wdata[2:0], 2) == 3'h7)
        ? 3'h0 : $past(reg_wdata[2:0], 2)))
        else $error("divide code does not follow select write");
    a_gate_on: assert property (reg_write && a == 16'h1300 && reg_wdata[2] |->
        ##[1:3] core3_clock_enable) else $error("clock enable did not rise");
    a_gate_off: assert property (reg_write && a == 16'h1300 && !reg_wdata[2] |->
        ##[1:3] !core3_clock_enable) else $error("clock enable did not fall");
    a_clear_walk: assert property (core3_memory_clear && $past(core3_memory_clear) |->
        core3_clear_address == $past(core3_clear_address) + 16'h0001)
        else $error("clear address skipped");
    a_clear_span: assert property (core3_memory_clear |->
        core3_clear_address < 16'(CLEAR_WORDS) && !core3_clock_enable)
        else $error("clear out of range or with clock on");
    a_ready_clearing: assert property (reg_read && a == 16'h1304 && core3_memory_clear
        |=> reg_rdata == 16'h0000) else $error("memory ready while clearing");
    a_status_upper: assert property (reg_read && a == 16'h1306 |=>
        reg_rdata[15:4] == 12'h000) else $error("clock status upper bits set");
    a_family_flag: assert property (fam [*4] |=> core3_family_44k1)
        else $error("family flag missing");
    a_base_family: assert property (!fam [*4] |=> !core3_family_44k1)
        else $error("family flag spurious");
    c_clear: cover property ($rose(core3_memory_clear));
    c_clash: cover property (reg_read && a == 16'h1307 ##1 reg_rdata != 16'h0000);
    c_family: cover property ($rose(core3_family_44k1));
endmodule : dsp_clock_memory_checker
bind dsp_clock_memory_control dsp_clock_memory_checker #(
    .ADDR_W(ADDR_W), .CLEAR_WORDS(CLEAR_WORDS)) u_checker (.clk_sys(clk_sys),
    .arst_n(arst_n), .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .sample_rate_code(sample_rate_code),
    .core3_clock_enable(core3_clock_enable), .core3_divide_code(core3_divide_code),
    .core3_family_44k1(core3_family_44k1), .core3_memory_clear(core3_memory_clear),
    .core3_clear_address(core3_clear_address));
`default_nettype wire

//--- testbench/dsp_clock_memory_control_test.sv
`timescale 1ns/10ps
`default_nettype none
module dsp_clock_memory_control_test;
    typedef struct packed {logic [2:0] code; logic [2:0] div;} row_s;
    row_s rows [8] = '{'{3'h0, 3'h0}, '{3'h1, 3'h1}, '{3'h2, 3'h2}, '{3'h3, 3'h3},
                       '{3'h4, 3'h4}, '{3'h5, 3'h5}, '{3'h6, 3'h6}, '{3'h7, 3'h0}};
    logic clk_sys = 1'b0, arst_n = 1'b0, soft_reset = 1'b0, reg_write = 1'b0;
    logic reg_read = 1'b0, m2 = 1'b0, on2 = 1'b0, clash = 1'b0;
    logic [15:0] reg_addr = 16'h0000, reg_wdata = 16'h0000, word = 16'h0000;
    logic [4:0] rate = 5'h00;
    logic [2:0] f2 = 3'h0;
    logic [15:0] reg_rdata, clr_a;
    logic en, run, fam, clr;
    logic [2:0] div;
    int errors = 0, total_checks = 0, clears = 0;
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) if (clr === 1'b1) clears++;
    dsp_clock_memory_control #(.CLEAR_WORDS(8)) u_dsp_clock_memory_control (
        .clk_sys(clk_sys), .arst_n(arst_n), .soft_reset(soft_reset), .reg_addr(reg_addr),
        .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .sample_rate_code(rate), .core2_memory_ready_in(m2),
        .core2_clock_on(on2), .core2_freq_code(f2), .core3_clash(clash),
        .core3_clash_word(word), .core3_clock_enable(en), .core3_run_enable(run),
        .core3_divide_code(div), .core3_family_44k1(fam), .core3_memory_clear(clr),
        .core3_clear_address(clr_a));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys);
    endtask : idle
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        idle(1);
        reg_write <= 1'b0;
        idle(1);
    endtask : wr
    task automatic rd(input logic [15:0] a, input logic [15:0] exp);
        reg_addr <= a;
        reg_read <= 1'b1;
        idle(1);
        reg_read <= 1'b0;
        #1 chk(reg_rdata, exp);
        idle(1);
    endtask : rd
    task automatic hit(input logic [15:0] w);
        word <= w;
        clash <= 1'b1;
        idle(4);
        clash <= 1'b0;
        idle(4);
    endtask : hit
    task automatic close_out;
        $display("checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : close_out
    initial
    begin
        idle(4000);
        errors++;
        close_out();
    end
    initial
    begin
        idle(12);
        arst_n <= 1'b1;
        idle(4);
        rd(16'h1300, 16'h0010);
        rd(16'h1301, 16'h0000);
        rd(16'h1304, 16'h0000);
        rd(16'h1306, 16'h0000);
        wr(16'h1307, 16'hFFFF);
        rd(16'h1307, 16'h0000);
        rd(16'h1305, 16'h0000);
        wr(16'h1300, 16'h0015);
        idle(3);
        chk({14'h0, en, run}, 16'h0003);
        rd(16'h1304, 16'h0001);
        $display("reset and enable test done");
        m2 <= 1'b1;
        on2 <= 1'b1;
        for (int i = 0; i < 8; i++)
        begin
            f2 <= rows[i].code;
            wr(16'h1301, {13'h0, rows[i].code});
            idle(4);
            chk({13'h0, div}, {13'h0, rows[i].div});
            if (rows[i].code != 3'h7)
            begin
                rd(16'h1306, {12'h0, rows[i].code, 1'b1});
                rd(16'h1206, {12'h0, rows[i].code, 1'b1});
            end
        end
        rd(16'h1204, 16'h0001);
        $display("clock code table test done");
        clears = 0;
        wr(16'h1300, 16'h0014);
        wr(16'h1300, 16'h0010);
        idle(20);
        chk(16'(clears), 16'h0000);
        wr(16'h1300, 16'h0000);
        idle(2);
        rd(16'h1304, 16'h0000);
        idle(14);
        chk(16'(clears), 16'h0008);
        rd(16'h1304, 16'h0000);
        hit(16'h1234);
        rd(16'h1307, 16'h1234);
        word <= 16'hBEEF;
        idle(4);
        rd(16'h1307, 16'h1234);
        clash <= 1'b1;
        idle(4);
        hit(16'h03FF);
        rd(16'h1307, 16'hBEEF);
        clears = 0;
        soft_reset <= 1'b1;
        idle(4);
        soft_reset <= 1'b0;
        idle(24);
        chk({15'h0, clears >= 8}, 16'h0001);
        rd(16'h1307, 16'h0000);
        $display("memory and clash test done");
        for (int i = 0; i < 4; i++)
        begin
            rate <= 5'(i * 7 + 8);
            idle(6);
            chk({15'h0, fam}, {15'h0, rate[4:3] == 2'b01});
        end
        wr(16'h1300, 16'h0010);
        clears = 0;
        arst_n <= 1'b0;
        idle(3);
        arst_n <= 1'b1;
        idle(20);
        chk(16'(clears), 16'h0000);
        rd(16'h1300, 16'h0010);
        $display("family and reset test done");
        close_out();
    end
endmodule : dsp_clock_memory_control_test
`default_nettype wire
